// File: core/ocp_pkg.sv
/*
 * Constants and carrier types of the overcurrent fault response block.
 * Assumes a 100 MHz system clock and a separately clocked host link.
 */
package ocp_pkg;

    // unit times and their cycle counts
    localparam int CLK_MHZ = 100;
    localparam int DELAY_UNIT_MS = 16;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * 1000 * CLK_MHZ;
    localparam int RETRY_UNIT_MS = 1;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * 1000 * CLK_MHZ;

    // link address
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;

    // command codes
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
    localparam logic [7:0] CMD_OC_ACTION = 8'h47;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
    localparam logic [7:0] CMD_ALERT_MASK = 8'hD1;
    localparam logic [7:0] CMD_INT_OT_ACTION = 8'hD6;
    localparam logic [7:0] CMD_RESTART_INTERVAL = 8'hDB;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hFD;

    // values after reset
    localparam logic [7:0] OC_ACTION_RST = 8'h00;
    localparam logic [7:0] INT_OT_ACTION_RST = 8'hC0;
    localparam logic [7:0] OPERATION_RST = 8'h80;
    localparam logic [7:0] RESTART_INTERVAL_RST = 8'h0A;

    // field positions
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam int OPERATION_ON_BIT = 7;
    localparam int SB_NONE_BIT = 0;
    localparam int SB_IOUT_OC_BIT = 4;
    localparam int SW_IOUT_BIT = 6;
    localparam int SI_OC_BIT = 7;

    // response and retry encodings
    localparam logic [1:0] RESP_CONST_I = 2'b00;
    localparam logic [1:0] RESP_UNSUPP = 2'b01;
    localparam logic [1:0] RESP_DELAYED = 2'b10;
    localparam logic [1:0] RESP_SHUTDOWN = 2'b11;
    localparam logic [2:0] RETRY_NONE = 3'b000;

    // host settings, one copy per clock domain
    typedef struct packed {
        logic page;
        logic [1:0][7:0] oc_action;
        logic [1:0] op_on;
        logic [1:0] alert_mask;
        logic [7:0] restart_interval_setting;
    } cfg_t;

    // last command taken on the link
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } evt_t;

    typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_LIMIT, ST_LATCH, ST_WAIT} chan_state_t;
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WDATA, PH_RDATA, PH_SKIP} link_phase_t;

endpackage : ocp_pkg

// File: core/oc_fault_ctrl.sv
/*
 * Overcurrent fault response for two channels with its serial command port.
 * Assumes external open-drain resolution and a link clock that stops between frames.
 */
// Behaviour
// - overcurrent sets status byte, word and current-status fault bits
// - each overcurrent fault asserts alert unless masked
// - response setting moves as one data byte on reads and writes
// - fault bits stay set until clear, restore, soft reset, output recycle or power
// - response 00 holds current at limit indefinitely; 01 unsupported
// - response 10 limits for the delay, then shuts down and applies retry setting if still limiting
// - response 11 shuts output at once, then applies retry setting
// - retry 000 never restarts; output stays off until run or operation toggles, or power
// - continuous retry restarts after each interval until commanded off
// - delay field counts 16 ms units before shutdown
// - delay field matters only in the delayed shutdown response
// - internal overtemperature setting reads 0xC0, read only, not paged
// - response byte at code 0x47, per page, read and write, default 0x00
`timescale 1ns/100ps
`default_nettype none

module oc_channel #(
    parameter int DELAY_CYC = ocp_pkg::DELAY_UNIT_CYC,
    parameter int RETRY_CYC = ocp_pkg::RETRY_UNIT_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // control
    input wire logic on_i,
    input wire logic oc_i,
    input wire logic [7:0] action_i,
    input wire logic [7:0] interval_i,
    // power stage and status
    output logic out_enable_o,
    output logic current_limit_o,
    output logic fault_pulse_o
);
    ocp_pkg::chan_state_t state;
    ocp_pkg::chan_state_t next_state;
    ocp_pkg::chan_state_t shut_state;
    logic [31:0] pre;
    logic [7:0] units;
    logic [31:0] unit_last;
    logic counting;
    logic [1:0] resp;
    logic [2:0] delay;

    assign resp = action_i[ocp_pkg::RESP_MSB:ocp_pkg::RESP_LSB];
    assign delay = action_i[ocp_pkg::DELAY_MSB:ocp_pkg::DELAY_LSB];

    // shutdown target: latched off or restart wait
    always_comb
    begin
        if (action_i[ocp_pkg::RETRY_MSB:ocp_pkg::RETRY_LSB] == ocp_pkg::RETRY_NONE)
            shut_state = ocp_pkg::ST_LATCH;
        else
            shut_state = ocp_pkg::ST_WAIT;
    end

    // response sequencing; turning off always wins
    always_comb
    begin
        next_state = state;
        if (!on_i)
            next_state = ocp_pkg::ST_OFF;
        else
            case (state)
                ocp_pkg::ST_OFF: next_state = ocp_pkg::ST_RUN;
                ocp_pkg::ST_RUN:
                    if (oc_i)
                        next_state = (resp == ocp_pkg::RESP_SHUTDOWN) ? shut_state
                                                                      : ocp_pkg::ST_LIMIT;
                ocp_pkg::ST_LIMIT:
                    if (!oc_i)
                        next_state = ocp_pkg::ST_RUN;
                    else if (resp == ocp_pkg::RESP_SHUTDOWN)
                        next_state = shut_state;
                    else if (resp == ocp_pkg::RESP_DELAYED && units == {5'h00, delay})
                        next_state = shut_state;
                ocp_pkg::ST_LATCH: next_state = ocp_pkg::ST_LATCH;
                ocp_pkg::ST_WAIT:
                    if (units == interval_i)
                        next_state = ocp_pkg::ST_RUN;
                default: next_state = ocp_pkg::ST_OFF;
            endcase
    end

    // state and power stage drives
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ocp_pkg::ST_OFF;
            out_enable_o <= 1'b0;
            current_limit_o <= 1'b0;
            fault_pulse_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            out_enable_o <= (next_state == ocp_pkg::ST_RUN) || (next_state == ocp_pkg::ST_LIMIT);
            current_limit_o <= (next_state == ocp_pkg::ST_LIMIT);
            fault_pulse_o <= on_i && (state == ocp_pkg::ST_RUN) && oc_i;
        end
    end

    // unit timer for the delay and the restart wait
    assign counting = (next_state == state) &&
                      ((state == ocp_pkg::ST_LIMIT && resp == ocp_pkg::RESP_DELAYED) ||
                       state == ocp_pkg::ST_WAIT);
    assign unit_last = (state == ocp_pkg::ST_WAIT) ? 32'(RETRY_CYC - 1)
                                                   : 32'(DELAY_CYC - 1);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre <= 32'h00000000;
            units <= 8'h00;
        end
        else if (!counting)
        begin
            pre <= 32'h00000000;
            units <= 8'h00;
        end
        else if (pre == unit_last)
        begin
            pre <= 32'h00000000;
            units <= units + 8'h01;
        end
        else
            pre <= pre + 32'h00000001;
    end
endmodule : oc_channel

module oc_fault_ctrl #(
    parameter logic [6:0] DEV_ADDR = ocp_pkg::DEV_ADDR_DEFAULT,
    parameter int DELAY_CYC = ocp_pkg::DELAY_UNIT_CYC,
    parameter int RETRY_CYC = ocp_pkg::RETRY_UNIT_CYC
) (
    // system clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // serial link: clock pin and open-drain data
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // open-drain alert toward the host
    output logic alert_o,
    output logic alert_oe_o,
    // channel pins
    input wire logic [1:0] run_i,
    input wire logic [1:0] oc_detect_i,
    output logic [1:0] out_enable_o,
    output logic [1:0] current_limit_o
);
    // link domain state
    ocp_pkg::cfg_t cfg_lnk;
    ocp_pkg::evt_t evt_lnk;
    ocp_pkg::link_phase_t phase;
    logic evt_tog;
    logic start_tog;
    logic start_ack;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] rbyte;
    logic [7:0] next_rbyte;
    logic [7:0] byte_in;
    logic ack_en;
    logic ridx;
    logic [1:0] flt_m;
    logic [1:0] flt_s;
    // system domain state
    ocp_pkg::cfg_t cfg_sys;
    logic [2:0] tog_sync;
    logic evt_fire;
    logic clear_all;
    logic [1:0] run_m;
    logic [1:0] run_s;
    logic [1:0] ocd_m;
    logic [1:0] ocd_s;
    logic [1:0] on;
    logic [1:0] on_d;
    logic [1:0] fault_pulse;
    logic [1:0] oc_fault;

    // start condition: data falling while the clock is high; a toggle survives the gap
    always_ff @(negedge sda_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            start_tog <= 1'b0;
        else if (scl_i)
            start_tog <= ~start_tog;
    end

    // fault flags into the link domain
    always_ff @(posedge scl_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flt_m <= 2'b00;
            flt_s <= 2'b00;
        end
        else
        begin
            flt_m <= oc_fault;
            flt_s <= flt_m;
        end
    end

    assign byte_in = {shift[6:0], sda_i};

    // read data for the current command and page
    always_comb
    begin
        next_rbyte = 8'h00;
        case (evt_lnk.cmd)
            ocp_pkg::CMD_PAGE: next_rbyte = {7'h00, cfg_lnk.page};
            ocp_pkg::CMD_OPERATION:
                next_rbyte[ocp_pkg::OPERATION_ON_BIT] = cfg_lnk.op_on[cfg_lnk.page];
            ocp_pkg::CMD_OC_ACTION: next_rbyte = cfg_lnk.oc_action[cfg_lnk.page];
            ocp_pkg::CMD_INT_OT_ACTION: next_rbyte = ocp_pkg::INT_OT_ACTION_RST;
            ocp_pkg::CMD_RESTART_INTERVAL: next_rbyte = cfg_lnk.restart_interval_setting;
            ocp_pkg::CMD_ALERT_MASK: next_rbyte = {7'h00, cfg_lnk.alert_mask[cfg_lnk.page]};
            ocp_pkg::CMD_STATUS_BYTE:
            begin
                next_rbyte[ocp_pkg::SB_NONE_BIT] = flt_s[cfg_lnk.page];
                next_rbyte[ocp_pkg::SB_IOUT_OC_BIT] = flt_s[cfg_lnk.page];
            end
            ocp_pkg::CMD_STATUS_WORD:
                if (ridx)
                    next_rbyte[ocp_pkg::SW_IOUT_BIT] = flt_s[cfg_lnk.page];
                else
                begin
                    next_rbyte[ocp_pkg::SB_NONE_BIT] = flt_s[cfg_lnk.page];
                    next_rbyte[ocp_pkg::SB_IOUT_OC_BIT] = flt_s[cfg_lnk.page];
                end
            ocp_pkg::CMD_STATUS_IOUT: next_rbyte[ocp_pkg::SI_OC_BIT] = flt_s[cfg_lnk.page];
            default: next_rbyte = 8'h00;
        endcase
    end

    // link protocol: bits taken on the rising clock, bytes handled at the eighth bit
    always_ff @(posedge scl_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase <= ocp_pkg::PH_IDLE;
            start_ack <= 1'b0;
            cnt <= 4'h0;
            shift <= 8'h00;
            rbyte <= 8'h00;
            ack_en <= 1'b0;
            ridx <= 1'b0;
            evt_tog <= 1'b0;
            evt_lnk <= '0;
            cfg_lnk <= {1'b0, {2{ocp_pkg::OC_ACTION_RST}}, 2'b11, 2'b00,
                        ocp_pkg::RESTART_INTERVAL_RST};
        end
        else if (start_tog != start_ack)
        begin
            start_ack <= start_tog;
            phase <= ocp_pkg::PH_ADDR;
            shift <= {7'h00, sda_i};
            cnt <= 4'h1;
            ack_en <= 1'b0;
        end
        else if (cnt == 4'h8)
        begin
            cnt <= 4'h0;
            ack_en <= 1'b0;
            if (phase == ocp_pkg::PH_RDATA && !ack_en)
            begin
                if (sda_i)
                    phase <= ocp_pkg::PH_SKIP; // host ends the read
                else
                begin
                    ridx <= ~ridx;
                    rbyte <= next_rbyte;
                end
            end
        end
        else if (cnt == 4'h7)
        begin
            cnt <= 4'h8;
            shift <= byte_in;
            case (phase)
                ocp_pkg::PH_ADDR:
                    if (byte_in[7:1] != DEV_ADDR)
                        phase <= ocp_pkg::PH_SKIP;
                    else if (byte_in[0])
                    begin
                        phase <= ocp_pkg::PH_RDATA;
                        ack_en <= 1'b1;
                        rbyte <= next_rbyte; // low byte first
                        ridx <= 1'b1; // the next fetch takes the high half
                    end
                    else
                    begin
                        phase <= ocp_pkg::PH_CMD;
                        ack_en <= 1'b1;
                    end
                ocp_pkg::PH_CMD:
                begin
                    phase <= ocp_pkg::PH_WDATA;
                    ack_en <= 1'b1;
                    ridx <= 1'b0;
                    evt_lnk <= {byte_in, 8'h00};
                    // send-byte commands act without a data byte
                    if (byte_in == ocp_pkg::CMD_CLEAR_FAULTS || byte_in == ocp_pkg::CMD_RESTORE_USER ||
                        byte_in == ocp_pkg::CMD_SOFT_RESET)
                        evt_tog <= ~evt_tog;
                    if (byte_in == ocp_pkg::CMD_RESTORE_USER || byte_in == ocp_pkg::CMD_SOFT_RESET)
                        cfg_lnk <= {cfg_lnk.page, {2{ocp_pkg::OC_ACTION_RST}}, 2'b11, 2'b00,
                                    ocp_pkg::RESTART_INTERVAL_RST};
                end
                ocp_pkg::PH_WDATA:
                begin
                    // one data byte per write; further bytes are not acknowledged
                    phase <= ocp_pkg::PH_SKIP;
                    ack_en <= 1'b1;
                    evt_lnk.data <= byte_in;
                    evt_tog <= ~evt_tog;
                    case (evt_lnk.cmd)
                        ocp_pkg::CMD_PAGE: cfg_lnk.page <= byte_in[0];
                        ocp_pkg::CMD_OPERATION:
                            cfg_lnk.op_on[cfg_lnk.page] <= byte_in[ocp_pkg::OPERATION_ON_BIT];
                        ocp_pkg::CMD_OC_ACTION: cfg_lnk.oc_action[cfg_lnk.page] <= byte_in;
                        ocp_pkg::CMD_ALERT_MASK: cfg_lnk.alert_mask[cfg_lnk.page] <= byte_in[0];
                        ocp_pkg::CMD_RESTART_INTERVAL: cfg_lnk.restart_interval_setting <= byte_in;
                        default: cfg_lnk <= cfg_lnk; // read-only codes drop the write
                    endcase
                end
                default: ack_en <= 1'b0;
            endcase
        end
        else
        begin
            cnt <= cnt + 4'h1;
            shift <= byte_in;
        end
    end

    // data pin drive changes on the falling clock, away from the sampling edge
    always_ff @(negedge scl_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            sda_oe_o <= (cnt == 4'h8 && ack_en) ||
                        (phase == ocp_pkg::PH_RDATA && cnt < 4'h8 && !rbyte[3'(4'h7 - cnt)]);
        end
    end

    // pins and link event into the system domain; settings stay still for many link
    // clocks after the toggle, so copying them on the synced edge is safe
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            run_m <= 2'b00;
            run_s <= 2'b00;
            ocd_m <= 2'b00;
            ocd_s <= 2'b00;
            tog_sync <= 3'b000;
        end
        else
        begin
            run_m <= run_i;
            run_s <= run_m;
            ocd_m <= oc_detect_i;
            ocd_s <= ocd_m;
            tog_sync <= {tog_sync[1:0], evt_tog};
        end
    end

    assign evt_fire = tog_sync[2] ^ tog_sync[1];
    assign clear_all = evt_fire && (evt_lnk.cmd == ocp_pkg::CMD_CLEAR_FAULTS ||
                                    evt_lnk.cmd == ocp_pkg::CMD_RESTORE_USER ||
                                    evt_lnk.cmd == ocp_pkg::CMD_SOFT_RESET);
    assign on = run_s & cfg_sys.op_on;

    // system copy of the host settings
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_sys <= {1'b0, {2{ocp_pkg::OC_ACTION_RST}}, 2'b11, 2'b00,
                        ocp_pkg::RESTART_INTERVAL_RST};
            on_d <= 2'b00;
        end
        else
        begin
            if (evt_fire)
                cfg_sys <= cfg_lnk;
            on_d <= on;
        end
    end

    // one response sequencer per channel
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        oc_channel #(
            .DELAY_CYC(DELAY_CYC),
            .RETRY_CYC(RETRY_CYC)
        ) u_chan (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .on_i(on[ch]),
            .oc_i(ocd_s[ch]),
            .action_i(cfg_sys.oc_action[ch]),
            .interval_i(cfg_sys.restart_interval_setting),
            .out_enable_o(out_enable_o[ch]),
            .current_limit_o(current_limit_o[ch]),
            .fault_pulse_o(fault_pulse[ch])
        );
    end

    // sticky fault bits: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oc_fault <= 2'b00;
        else
            oc_fault <= fault_pulse | (oc_fault & ~(on & ~on_d) & {2{~clear_all}});
    end

    // alert set by an unmasked fault, held until clear, restore or soft reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alert_o <= 1'b0;
            alert_oe_o <= 1'b0;
        end
        else
        begin
            alert_o <= 1'b0;
            if (|(fault_pulse & ~cfg_sys.alert_mask))
                alert_oe_o <= 1'b1;
            else if (clear_all)
                alert_oe_o <= 1'b0;
        end
    end
endmodule : oc_fault_ctrl

`default_nettype wire

// File: verif/ocp_host.sv
/* Link host model: start, bytes, stop, 80 ns clock.
   Assumes a pull-up on the data wire. */
`timescale 1ns/100ps
`default_nettype none
module ocp_host (
    // link pins
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    // idle: clock high, data released
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // one bit; data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        #20 sda_oe_o = !b;
        #20 scl_o = 1'b1;
        #20 r = sda_i;
        #20 scl_o = 1'b0;
    endtask : bit_x
    // serves as start and as repeated start
    task automatic start;
        #20 sda_oe_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_oe_o = 1'b1;
        #20 scl_o = 1'b0;
    endtask : start
    task automatic stop;
        #20 sda_oe_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_oe_o = 1'b0;
    endtask : stop
    // eight bits msb first, then the acknowledge clock
    task automatic byte_x(input logic [7:0] d, input logic nak, output logic [7:0] q,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(nak, r);
        ack = !r;
    endtask : byte_x
    // write byte, or send byte when has_d is low
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic has_d,
        output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        byte_x({ocp_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, a0);
        byte_x(c, 1'b1, q, a1);
        a2 = 1'b1;
        if (has_d)
            byte_x(d, 1'b1, q, a2);
        stop();
        ok = a0 && a1 && a2;
    endtask : wr
    // two bytes read back, first acked, second refused
    task automatic rd(input logic [7:0] c, output logic [15:0] q);
        logic [7:0] x;
        logic a;
        start();
        byte_x({ocp_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, x, a);
        byte_x(c, 1'b1, x, a);
        start();
        byte_x({ocp_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, x, a);
        byte_x(8'hFF, 1'b0, q[7:0], a);
        byte_x(8'hFF, 1'b1, q[15:8], a);
        stop();
    endtask : rd
endmodule : ocp_host
`default_nettype wire

// File: verif/oc_fault_ctrl_asserts.sv
/* Port checker bound to oc_fault_ctrl.
   Assumes the link clock is sampled as data. */
`timescale 1ns/100ps
`default_nettype none
module oc_fault_ctrl_asserts #(
    parameter int DELAY_CYC = 20,
    parameter int RETRY_CYC = 10
) (
    // top-level ports
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic alert_o,
    input wire logic alert_oe_o,
    input wire logic [1:0] run_i,
    input wire logic [1:0] oc_detect_i,
    input wire logic [1:0] out_enable_o,
    input wire logic [1:0] current_limit_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [3:0] hi_cnt;
    // samples since the link clock was last low
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hi_cnt <= 4'h0;
        else if (!scl_i)
            hi_cnt <= 4'h0;
        else if (hi_cnt != 4'hF)
            hi_cnt <= hi_cnt + 4'h1;
    end
    property p_limit_in_run;
        (current_limit_o & ~out_enable_o) == 2'h0;
    endproperty
    a_limit_in_run: assert property (p_limit_in_run) else $error("limit while off");
    property p_off_ch0;
        !run_i[0] [*6] |-> !out_enable_o[0];
    endproperty
    a_off_ch0: assert property (p_off_ch0) else $error("ch0 on without run");
    property p_off_ch1;
        !run_i[1] [*6] |-> !out_enable_o[1];
    endproperty
    a_off_ch1: assert property (p_off_ch1) else $error("ch1 on without run");
    property p_limit_cause;
        $rose(current_limit_o[0]) |-> $past(oc_detect_i[0], 2) || $past(oc_detect_i[0], 3);
    endproperty
    a_limit_cause: assert property (p_limit_cause) else $error("limit without oc");
    property p_limit_ends;
        !oc_detect_i[0] [*6] |-> !current_limit_o[0];
    endproperty
    a_limit_ends: assert property (p_limit_ends) else $error("limit outlives oc");
    property p_alert_cause;
        $rose(alert_oe_o) |-> ($past(oc_detect_i, 3) | $past(oc_detect_i, 4)) != 2'h0;
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without fault");
    property p_sda_low_scl;
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_sda_low_scl: assert property (p_sda_low_scl) else $error("data moved, clock high");
    property p_alert_clear;
        $fell(alert_oe_o) |-> hi_cnt < 4'hC;
    endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("alert dropped idle");
    property p_open_drain;
        sda_o == 1'b0 && alert_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    c_limit: cover property ($rose(current_limit_o[0]));
    c_shut: cover property ($fell(out_enable_o[1]) && oc_detect_i[1]);
    c_clear: cover property ($fell(alert_oe_o));
endmodule : oc_fault_ctrl_asserts
bind oc_fault_ctrl oc_fault_ctrl_asserts #(.DELAY_CYC(DELAY_CYC), .RETRY_CYC(RETRY_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o), .run_i(run_i),
    .oc_detect_i(oc_detect_i), .out_enable_o(out_enable_o), .current_limit_o(current_limit_o));
`default_nettype wire

// File: verif/overcurrent_fault_response_test.sv
/* Self-checking bench: link host model, channel pins driven here.
   Assumes delay and retry units of 20 and 10 cycles. */
`timescale 1ns/100ps
`default_nettype none
module overcurrent_fault_response_test;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] run_i = 2'h0;
    logic [1:0] oc_detect_i = 2'h0;
    logic scl, host_oe, sda_o, sda_oe_o, alert_o, alert_oe_o, ok;
    logic [1:0] out_enable_o, current_limit_o;
    logic [15:0] q;
    int miscompares = 0;
    int check_count = 0;
    wire logic sda = !(sda_oe_o || host_oe); // pulled-up wire
    always #5 clk_sys_i = !clk_sys_i;
    oc_fault_ctrl #(.DELAY_CYC(20), .RETRY_CYC(10)) u_oc_fault_ctrl (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .alert_o(alert_o), .alert_oe_o(alert_oe_o), .run_i(run_i), .oc_detect_i(oc_detect_i),
        .out_enable_o(out_enable_o), .current_limit_o(current_limit_o));
    ocp_host u_ocp_host (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc
    // bounded wait for an enable level; running out counts as a mismatch
    task automatic wait_en(input int c, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && out_enable_o[c] !== lvl; i++)
            cyc(1);
        if (i == lim)
        begin
            $display("[FAIL] enable wait expected %h seen %h", lvl, out_enable_o[c]);
            miscompares++;
            end_of_test();
        end
    endtask : wait_en
    // 1 us after a write lets it cross domains
    task automatic w(input logic [7:0] c, input logic [7:0] d, input logic has_d);
        u_ocp_host.wr(c, d, has_d, ok);
        chk($sformatf("ack %h", c), ok, 1'b1);
        cyc(100);
    endtask : w
    task automatic r(input logic [7:0] c, input logic [15:0] e);
        u_ocp_host.rd(c, q);
        chk($sformatf("cmd %h", c), q, e);
        cyc(1);
    endtask : r
    initial
    begin
        cyc(10);
        rst_n_i = 1'b1;
        run_i = 2'h3;
        cyc(10);
        chk("enable", out_enable_o, 2'h3);
        r(8'h47, 16'h0000);
        r(8'hD6, 16'hC0C0);
        w(8'hD6, 8'h55, 1'b1);
        w(8'h00, 8'h01, 1'b1);
        r(8'hD6, 16'hC0C0);
        w(8'h47, 8'h9A, 1'b1);
        r(8'h47, 16'h9A9A);
        w(8'h00, 8'h00, 1'b1);
        r(8'h47, 16'h0000);
        // constant current on channel 0
        oc_detect_i[0] = 1'b1;
        cyc(300);
        chk("held", {out_enable_o[0], current_limit_o[0], alert_oe_o}, 3'h7);
        r(8'h78, 16'h1111);
        r(8'h79, 16'h4011);
        r(8'h7B, 16'h8080);
        oc_detect_i[0] = 1'b0;
        cyc(10);
        chk("limit off", current_limit_o[0], 1'b0);
        r(8'h7B, 16'h8080);
        w(8'h03, 8'h00, 1'b0);
        chk("alert clear", alert_oe_o, 1'b0);
        r(8'h78, 16'h0000);
        // delayed shutdown on channel 1: delay 2 units, retry every 5 units
        w(8'hDB, 8'h05, 1'b1);
        repeat (2)
        begin
            oc_detect_i[1] = 1'b1;
            cyc(30);
            oc_detect_i[1] = 1'b0;
            cyc(10);
        end
        chk("ch1 survives", out_enable_o[1], 1'b1);
        oc_detect_i[1] = 1'b1;
        cyc(36);
        chk("ch1 on", out_enable_o[1], 1'b1);
        wait_en(1, 1'b0, 20);
        oc_detect_i[1] = 1'b0;
        cyc(40);
        chk("ch1 off", out_enable_o[1], 1'b0);
        wait_en(1, 1'b1, 25);
        // immediate shutdown, no retry, masked alert, delay field ignored
        w(8'h47, 8'hC7, 1'b1);
        w(8'hD1, 8'h01, 1'b1);
        w(8'h03, 8'h00, 1'b0);
        oc_detect_i[0] = 1'b1;
        wait_en(0, 1'b0, 8);
        chk("masked", alert_oe_o, 1'b0);
        oc_detect_i[0] = 1'b0;
        r(8'h78, 16'h1111);
        chk("latched", out_enable_o[0], 1'b0);
        run_i[0] = 1'b0;
        cyc(10);
        run_i[0] = 1'b1;
        wait_en(0, 1'b1, 10);
        r(8'h78, 16'h0000);
        w(8'h16, 8'h00, 1'b0);
        r(8'h47, 16'h0000);
        end_of_test();
    end
endmodule : overcurrent_fault_response_test
`default_nettype wire
